// [verilog/bsu_pkg.sv]
// Constants, types and helpers for the byte and string instruction unit.
// Assumes a 16-bit word-addressed memory and a 32-bit APB register bus.
package bsu_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int unsigned WORD_W  = 16;
   localparam int unsigned BYTE_W  = 8;
   localparam int unsigned LEN_W   = 12;
   localparam int unsigned BADDR_W = 17;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_ACC    = 8'h00;
   localparam logic [7:0] OFF_EXT    = 8'h04;
   localparam logic [7:0] OFF_BASE   = 8'h08;
   localparam logic [7:0] OFF_INDEX  = 8'h0C;
   localparam logic [7:0] OFF_PC     = 8'h10;
   localparam logic [7:0] OFF_CMD    = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;

   localparam logic [15:0] RST_WORD = 16'h0000;

   // ------------------------------------------------------------------
   // Instruction codes
   // ------------------------------------------------------------------
   localparam logic [15:0] CODE_LOAD  = 16'hC480;
   localparam logic [15:0] CODE_STORE = 16'hC580;
   localparam logic [15:0] CODE_FILL  = 16'hC058;
   localparam logic [15:0] CODE_OVERLAP_SAFE_BYTE_MOVE  = 16'hC059;
   localparam logic [15:0] CODE_FORWARD_BYTE_MOVE = 16'hC05A;

   // ------------------------------------------------------------------
   // Control-word fields and status bits
   // ------------------------------------------------------------------
   localparam int BIT_RIGHT = 15;
   localparam int BIT_ALT   = 14;
   localparam int BIT_MARK  = 13;
   localparam int BIT_WORK  = 12;

   localparam int ST_BUSY = 0;
   localparam int ST_SKIP = 1;
   localparam int ST_ERR  = 2;
   localparam int ST_INTR = 3;
   localparam int ST_BAD  = 4;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      BSU_IDLE   = 3'b000,
      BSU_INIT   = 3'b001,
      BSU_STEP   = 3'b011,
      BSU_RD_SRC = 3'b010,
      BSU_RD_DST = 3'b110,
      BSU_WR_DST = 3'b111,
      BSU_DONE   = 3'b101
   } bsu_state_e;

   typedef enum logic [2:0] {
      OP_NONE  = 3'h0,
      OP_LOAD  = 3'h1,
      OP_STORE = 3'h2,
      OP_FILL  = 3'h3,
      OP_OVERLAP_SAFE_BYTE_MOVE  = 3'h4,
      OP_FORWARD_BYTE_MOVE = 3'h5
   } bsu_op_e;

   typedef enum logic [1:0] {
      END_SKIP = 2'h0,
      END_NEXT = 2'h1,
      END_ERR  = 2'h2,
      END_INTR = 2'h3
   } bsu_end_e;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        alt_page;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bsu_mem_s;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic bsu_op_e bsu_decode(input logic [15:0] code);
      case (code)
         CODE_LOAD:  bsu_decode = OP_LOAD;
         CODE_STORE: bsu_decode = OP_STORE;
         CODE_FILL:  bsu_decode = OP_FILL;
         CODE_OVERLAP_SAFE_BYTE_MOVE:  bsu_decode = OP_OVERLAP_SAFE_BYTE_MOVE;
         CODE_FORWARD_BYTE_MOVE: bsu_decode = OP_FORWARD_BYTE_MOVE;
         default:    bsu_decode = OP_NONE;
      endcase
   endfunction : bsu_decode

   function automatic logic [11:0] bsu_min(input logic [11:0] a, input logic [11:0] b);
      bsu_min = (a < b) ? a : b;
   endfunction : bsu_min

   function automatic logic [15:0] bsu_merge(input logic [15:0] w, input logic [7:0] b,
                                             input logic right);
      bsu_merge = right ? {w[15:8], b} : {b, w[7:0]};
   endfunction : bsu_merge

   function automatic logic [7:0] bsu_pick(input logic [15:0] w, input logic right);
      bsu_pick = right ? w[7:0] : w[15:8];
   endfunction : bsu_pick

endpackage : bsu_pkg

// [verilog/bsu_top.sv]
// Byte and string instruction unit: single-byte load/store and descriptor strings.
// Assumes an APB master, and a word memory that holds mem_out until mem_ack.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps

module bsu_top
   import bsu_pkg::*;
#(
   parameter int unsigned DATA_W = 16
)(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Sequencer
   input  wire logic        irq_pending,
   output logic             instr_done,
   // Memory port
   output bsu_mem_s         mem_out,
   input  wire logic        mem_ack,
   input  wire logic [15:0] mem_rdata
);

   if (DATA_W != WORD_W) begin : g_chk
      $error("bsu_top serves only 16-bit words");
   end

   bsu_state_e  state_reg;
   bsu_op_e     op_reg;
   bsu_end_e    end_reg;
   logic [15:0] a_reg, d_reg, t_reg, x_reg, pc_reg;
   logic [4:0]  status_reg;
   logic [7:0]  byte_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg, pslverr_reg, done_reg;
   bsu_mem_s    mem_reg;

   // ------------------------------------------------------------------
   // Address arithmetic
   // ------------------------------------------------------------------
   logic [16:0] src_ba, dst_ba, src_cur, dst_cur, src_last;
   logic [15:0] sb_addr;
   logic [11:0] rem_len, overlap_safe_byte_move_n;
   logic        back, ovl, busy;
   logic        apb_wr, apb_setup;
   bsu_op_e     cmd_op;

   assign busy    = (state_reg != BSU_IDLE);
   assign src_ba  = {a_reg, d_reg[BIT_RIGHT]};
   assign dst_ba  = {x_reg, t_reg[BIT_RIGHT]};
   assign back    = t_reg[BIT_WORK];
   // Backward copy keeps the pointers at the field end and counts down by moved bytes.
   assign src_cur = back ? 17'(src_ba - {5'h00, t_reg[11:0]} - 17'h00001) : src_ba;
   assign dst_cur = back ? 17'(dst_ba - {5'h00, t_reg[11:0]} - 17'h00001) : dst_ba;
   assign overlap_safe_byte_move_n  = bsu_min(d_reg[11:0], t_reg[11:0]);
   assign sb_addr = 16'(t_reg + {1'b0, x_reg[15:1]});
   assign src_last = 17'(src_cur + {5'h00, rem_len} - 17'h00001);
   assign cmd_op  = bsu_decode(pwdata[15:0]);

   always_comb begin
      case (op_reg)
         OP_OVERLAP_SAFE_BYTE_MOVE:  rem_len = d_reg[11:0];
         OP_FORWARD_BYTE_MOVE: rem_len = overlap_safe_byte_move_n;
         default:  rem_len = t_reg[11:0];
      endcase
   end

   // A later source byte still unread shares the word about to be written.
   always_comb begin
      ovl = (rem_len > 12'h001) &&
            (dst_cur[16:1] >= 16'(17'(src_cur + 17'h00001) >> 1)) &&
            (dst_cur[16:1] <= src_last[16:1]);
   end

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pready_reg && pwrite && !pslverr_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= apb_setup;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         if (apb_setup) begin
            case (paddr)
               OFF_ACC:    prdata_reg <= {16'h0000, a_reg};
               OFF_EXT:    prdata_reg <= {16'h0000, d_reg};
               OFF_BASE:   prdata_reg <= {16'h0000, t_reg};
               OFF_INDEX:  prdata_reg <= {16'h0000, x_reg};
               OFF_PC:     prdata_reg <= {16'h0000, pc_reg};
               OFF_CMD:    prdata_reg <= 32'h0000_0000;
               OFF_STATUS: prdata_reg <= {27'h0000000, status_reg};
               default:    pslverr_reg <= 1'b1;
            endcase
            if (pwrite && busy && paddr != OFF_STATUS) begin
               pslverr_reg <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= BSU_IDLE;
         op_reg    <= OP_NONE;
         end_reg   <= END_NEXT;
      end else begin
         case (state_reg)
            BSU_IDLE: begin
               // Accepted on every program level; no privilege is checked.
               if (apb_wr && paddr == OFF_CMD && cmd_op != OP_NONE) begin
                  op_reg    <= cmd_op;
                  state_reg <= BSU_INIT;
               end
            end
            BSU_INIT: begin
               if (op_reg == OP_LOAD || op_reg == OP_STORE) begin
                  state_reg <= BSU_RD_DST;
               end else begin
                  state_reg <= BSU_STEP;
               end
            end
            BSU_STEP: begin
               if (rem_len == 12'h000) begin
                  end_reg   <= END_SKIP;
                  state_reg <= BSU_DONE;
               end else if (irq_pending) begin
                  end_reg   <= END_INTR;
                  state_reg <= BSU_DONE;
               end else if (op_reg == OP_FILL) begin
                  state_reg <= BSU_RD_DST;
               end else begin
                  state_reg <= BSU_RD_SRC;
               end
            end
            BSU_RD_SRC: begin
               if (mem_ack) begin
                  if (op_reg == OP_FORWARD_BYTE_MOVE && ovl) begin
                     end_reg   <= END_ERR;
                     state_reg <= BSU_DONE;
                  end else begin
                     state_reg <= BSU_RD_DST;
                  end
               end
            end
            BSU_RD_DST: begin
               if (mem_ack) begin
                  if (op_reg == OP_LOAD) begin
                     end_reg   <= END_NEXT;
                     state_reg <= BSU_DONE;
                  end else begin
                     state_reg <= BSU_WR_DST;
                  end
               end
            end
            BSU_WR_DST: begin
               if (mem_ack) begin
                  if (op_reg == OP_STORE) begin
                     end_reg   <= END_NEXT;
                     state_reg <= BSU_DONE;
                  end else begin
                     state_reg <= BSU_STEP;
                  end
               end
            end
            BSU_DONE: begin
               state_reg <= BSU_IDLE;
            end
            default: begin
               state_reg <= BSU_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Memory requests
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_reg  <= '0;
         byte_reg <= 8'h00;
      end else begin
         if (mem_reg.req && mem_ack) begin
            mem_reg.req <= 1'b0;
         end
         if (state_reg == BSU_INIT && (op_reg == OP_LOAD || op_reg == OP_STORE)) begin
            mem_reg <= '{req: 1'b1, we: 1'b0, alt_page: 1'b0, addr: sb_addr,
                         wdata: RST_WORD};
         end
         if (state_reg == BSU_STEP && rem_len != 12'h000 && !irq_pending) begin
            if (op_reg == OP_FILL) begin
               mem_reg <= '{req: 1'b1, we: 1'b0, alt_page: t_reg[BIT_ALT],
                            addr: dst_cur[16:1], wdata: RST_WORD};
            end else begin
               mem_reg <= '{req: 1'b1, we: 1'b0, alt_page: d_reg[BIT_ALT],
                            addr: src_cur[16:1], wdata: RST_WORD};
            end
         end
         if (state_reg == BSU_RD_SRC && mem_ack) begin
            byte_reg <= bsu_pick(mem_rdata, src_cur[0]);
            if (!(op_reg == OP_FORWARD_BYTE_MOVE && ovl)) begin
               mem_reg <= '{req: 1'b1, we: 1'b0, alt_page: t_reg[BIT_ALT],
                            addr: dst_cur[16:1], wdata: RST_WORD};
            end
         end
         if (state_reg == BSU_RD_DST && mem_ack && op_reg != OP_LOAD) begin
            mem_reg.req <= 1'b1;
            mem_reg.we  <= 1'b1;
            if (op_reg == OP_STORE) begin
               mem_reg.wdata <= bsu_merge(mem_rdata, a_reg[7:0], x_reg[0]);
            end else if (op_reg == OP_FILL) begin
               mem_reg.wdata <= bsu_merge(mem_rdata, a_reg[7:0], dst_cur[0]);
            end else begin
               mem_reg.wdata <= bsu_merge(mem_rdata, byte_reg, dst_cur[0]);
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Architectural registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_reg      <= RST_WORD;
         d_reg      <= RST_WORD;
         t_reg      <= RST_WORD;
         x_reg      <= RST_WORD;
         pc_reg     <= RST_WORD;
         status_reg <= 5'h00;
         done_reg   <= 1'b0;
      end else begin
         done_reg <= (state_reg == BSU_DONE);
         if (!busy && apb_wr) begin
            case (paddr)
               OFF_ACC:   a_reg  <= pwdata[15:0];
               OFF_EXT:   d_reg  <= pwdata[15:0];
               OFF_BASE:  t_reg  <= pwdata[15:0];
               OFF_INDEX: x_reg  <= pwdata[15:0];
               OFF_PC:    pc_reg <= pwdata[15:0];
               OFF_CMD:   status_reg <= {cmd_op == OP_NONE, 3'h0, cmd_op != OP_NONE};
               default:   status_reg <= status_reg;
            endcase
         end
         // A set resume mark means the working state is already in place.
         if (state_reg == BSU_INIT && op_reg == OP_OVERLAP_SAFE_BYTE_MOVE && !t_reg[BIT_MARK]) begin
            d_reg[11:0] <= overlap_safe_byte_move_n;
            t_reg[11:0] <= 12'h000;
            t_reg[BIT_MARK] <= 1'b1;
            if (dst_ba > src_ba) begin
               // Destination above source: copy from the top down.
               t_reg[BIT_WORK] <= 1'b1;
               {a_reg, d_reg[BIT_RIGHT]} <= 17'(src_ba + {5'h00, overlap_safe_byte_move_n});
               {x_reg, t_reg[BIT_RIGHT]} <= 17'(dst_ba + {5'h00, overlap_safe_byte_move_n});
            end
         end else if (state_reg == BSU_INIT && op_reg != OP_LOAD && op_reg != OP_STORE) begin
            t_reg[BIT_MARK] <= 1'b1;
         end
         if (state_reg == BSU_RD_DST && mem_ack && op_reg == OP_LOAD) begin
            a_reg <= {8'h00, bsu_pick(mem_rdata, x_reg[0])};
         end
         if (state_reg == BSU_WR_DST && mem_ack && op_reg != OP_STORE) begin
            case (op_reg)
               OP_FILL: begin
                  t_reg[11:0] <= 12'(t_reg[11:0] - 12'h001);
                  {x_reg, t_reg[BIT_RIGHT]} <= 17'(dst_ba + 17'h00001);
               end
               OP_OVERLAP_SAFE_BYTE_MOVE: begin
                  d_reg[11:0] <= 12'(d_reg[11:0] - 12'h001);
                  t_reg[11:0] <= 12'(t_reg[11:0] + 12'h001);
                  if (!back) begin
                     {a_reg, d_reg[BIT_RIGHT]} <= 17'(src_ba + 17'h00001);
                     {x_reg, t_reg[BIT_RIGHT]} <= 17'(dst_ba + 17'h00001);
                  end
               end
               default: begin
                  d_reg[11:0] <= 12'(d_reg[11:0] - 12'h001);
                  t_reg[11:0] <= 12'(t_reg[11:0] - 12'h001);
                  {a_reg, d_reg[BIT_RIGHT]} <= 17'(src_ba + 17'h00001);
                  {x_reg, t_reg[BIT_RIGHT]} <= 17'(dst_ba + 17'h00001);
               end
            endcase
         end
         if (state_reg == BSU_DONE) begin
            status_reg[ST_BUSY] <= 1'b0;
            status_reg[ST_SKIP] <= (end_reg == END_SKIP);
            status_reg[ST_ERR]  <= (end_reg == END_ERR);
            status_reg[ST_INTR] <= (end_reg == END_INTR);
            if (end_reg != END_INTR) begin
               if (op_reg != OP_LOAD && op_reg != OP_STORE) begin
                  t_reg[BIT_MARK] <= 1'b0;
                  t_reg[BIT_WORK] <= 1'b0;
                  d_reg[BIT_WORK] <= 1'b0;
               end
               pc_reg <= 16'(pc_reg + ((end_reg == END_SKIP) ? 16'h0002 : 16'h0001));
            end
         end
      end
   end

   assign prdata     = prdata_reg;
   assign pready     = pready_reg;
   assign pslverr    = pslverr_reg;
   assign instr_done = done_reg;
   assign mem_out    = mem_reg;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_load_read;
      state_reg == BSU_RD_DST && op_reg == OP_LOAD && mem_ack;
   endsequence
   sequence s_finish(bsu_end_e e);
      state_reg == BSU_DONE && end_reg == e;
   endsequence

   a_single_addr: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == BSU_RD_DST && (op_reg == OP_LOAD || op_reg == OP_STORE) && mem_out.req)
      |-> mem_out.addr == 16'(t_reg + {1'b0, x_reg[15:1]}))
      else $error("single byte address wrong");
   a_load_clear: assert property (@(posedge pclk) disable iff (!presetn)
      s_load_read ##1 1'b1 |-> a_reg[15:8] == 8'h00 &&
      a_reg[7:0] == ($past(x_reg[0]) ? $past(mem_rdata[7:0]) : $past(mem_rdata[15:8])))
      else $error("loaded byte wrong");
   a_store_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (mem_out.req && mem_out.we && op_reg == OP_STORE) |->
      (x_reg[0] ? mem_out.wdata[7:0] == a_reg[7:0] : mem_out.wdata[15:8] == a_reg[7:0]))
      else $error("stored byte wrong");
   a_alt_page: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == BSU_RD_SRC && mem_out.req) |-> mem_out.alt_page == d_reg[BIT_ALT])
      else $error("source page table select wrong");
   a_dst_page: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg inside {BSU_RD_DST, BSU_WR_DST} && mem_out.req) |->
      mem_out.alt_page == (op_reg inside {OP_LOAD, OP_STORE} ? 1'b0 : t_reg[BIT_ALT]))
      else $error("destination page table select wrong");
   a_mem_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (mem_out.req && !mem_ack) |=> mem_out.req && $stable(mem_out.addr))
      else $error("memory request dropped early");
   a_fill_end: assert property (@(posedge pclk) disable iff (!presetn)
      (s_finish(END_SKIP) and (op_reg == OP_FILL)) ##1 1'b1 |-> t_reg[11:0] == 12'h000)
      else $error("fill length not zero");
   a_work_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == BSU_DONE && end_reg != END_INTR && op_reg inside {OP_OVERLAP_SAFE_BYTE_MOVE, OP_FORWARD_BYTE_MOVE})
      |=> t_reg[13:12] == 2'b00 && !d_reg[BIT_WORK])
      else $error("working bits left set");
   a_fwd_order: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == BSU_WR_DST && mem_ack && op_reg == OP_FORWARD_BYTE_MOVE)
      |=> {a_reg, d_reg[BIT_RIGHT]} == 17'($past(src_ba) + 17'h00001))
      else $error("forward move not ascending");
   a_skip_pc: assert property (@(posedge pclk) disable iff (!presetn)
      s_finish(END_SKIP) |=> pc_reg == 16'($past(pc_reg) + 16'h0002) ##1 !busy)
      else $error("skip return counter wrong");
   a_err_pc: assert property (@(posedge pclk) disable iff (!presetn)
      s_finish(END_ERR) |=> pc_reg == 16'($past(pc_reg) + 16'h0001) && status_reg[ST_ERR])
      else $error("error return wrong");

endmodule : bsu_top

// [testbench/bsu_mem_model.sv]
// Word memory model that stands on the memory port of the byte unit.
// Assumes req is held with address and data until the ack edge.
`timescale 1ns/1ps
module bsu_mem_model
   import bsu_pkg::*;
(
   input  wire logic       pclk,
   input  wire bsu_mem_s   mem_in,
   input  wire logic [1:0] lat,
   output logic            mem_ack,
   output logic [15:0]     mem_rdata
);
   logic [15:0] ram [0:127];
   logic [1:0]  cnt;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 16'h0000;
      cnt = 2'h0;
   end
   // Read data is scrambled outside the ack cycle so it cannot be used late.
   always @(posedge pclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_in.req && !mem_ack) begin
         if (cnt == lat) begin
            cnt <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_in.we) ram[mem_in.addr[6:0]] <= mem_in.wdata;
            else mem_rdata <= ram[mem_in.addr[6:0]];
         end else cnt <= cnt + 2'h1;
      end
   end
endmodule : bsu_mem_model

// [testbench/test_byte_string_instruction_unit.sv]
// Self-checking bench for the byte and string instruction unit.
// Assumes registers reached over APB and the memory model on the memory port.
`timescale 1ns/1ps
module test_byte_string_instruction_unit;
   import bsu_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_done, mem_ack, e, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] mem_rdata;
   logic [1:0]  lat;
   bsu_mem_s    mem_out;
   int n_fail, n_checks;
   bsu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_pending(irq), .instr_done(instr_done), .mem_out(mem_out),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   bsu_mem_model mem (.pclk(pclk), .mem_in(mem_out), .lat(lat), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] x);
      n_checks++;
      if (seen !== x) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", s, x, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [15:0] x, input string s);
      apb(1'b0, a, 16'h0000);
      chk(s, r[15:0], x);
   endtask : rd
   task automatic setr(input logic [15:0] a, d, t, x);
      apb(1'b1, OFF_ACC, a); apb(1'b1, OFF_EXT, d);
      apb(1'b1, OFF_BASE, t); apb(1'b1, OFF_INDEX, x); // Resume mark kept clear.
   endtask : setr
   task automatic run(input logic [15:0] c);
      apb(1'b1, OFF_CMD, c);
      for (int i = 0; i < 800 && instr_done !== 1'b1; i++) @(posedge pclk);
      if (instr_done !== 1'b1) begin
         n_fail++;
         $display("MISMATCH instr_done expected 1 seen 0");
      end
      @(posedge pclk);
   endtask : run
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   initial begin
      #400000;
      n_fail++;
      conclude();
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; lat = 2'h0; n_fail = 0; n_checks = 0; irq = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      mem.ram[18] = 16'hA55A;
      setr(16'hFFFF, 16'h0000, 16'h0010, 16'h0005);
      run(CODE_LOAD);
      rd(OFF_ACC, 16'h005A, "acc load");
      rd(OFF_PC, 16'h0001, "pc load");
      lat <= 2'h2;
      apb(1'b1, OFF_ACC, 16'h1233); apb(1'b1, OFF_INDEX, 16'h0004);
      run(CODE_STORE);
      chk("store word", mem.ram[18], 16'h335A);
      rd(OFF_ACC, 16'h1233, "acc store");
      $display("single byte test done");
      mem.ram[32] = 16'h1111; mem.ram[33] = 16'h2222;
      setr(16'h0077, 16'h0000, 16'h8003, 16'h0020);
      irq <= 1'b1;
      run(CODE_FILL);
      rd(OFF_STATUS, 16'h0008, "fill intr");
      rd(OFF_BASE, 16'hA003, "fill mark");
      rd(OFF_PC, 16'h0002, "pc intr");
      irq <= 1'b0;
      run(CODE_FILL);
      chk("fill w0", mem.ram[32], 16'h1177);
      chk("fill w1", mem.ram[33], 16'h7777);
      rd(OFF_INDEX, 16'h0022, "fill addr");
      rd(OFF_BASE, 16'h0000, "fill ctl");
      rd(OFF_STATUS, 16'h0002, "fill status");
      rd(OFF_PC, 16'h0004, "pc fill");
      $display("fill test done");
      lat <= 2'h0;
      for (int k = 0; k < 2; k++) begin
         mem.ram[48] = 16'h0102; mem.ram[49] = 16'h0304; mem.ram[50] = 16'h0506;
         setr(16'h0030, 16'h0004, 16'h8005, 16'h0030);
         run(k == 0 ? CODE_OVERLAP_SAFE_BYTE_MOVE : CODE_FORWARD_BYTE_MOVE);
      end
      rd(OFF_STATUS, 16'h0004, "fwd overlap");
      rd(OFF_PC, 16'h0007, "pc error");
      setr(16'h0030, 16'h0004, 16'h8005, 16'h0030);
      mem.ram[48] = 16'h0102; mem.ram[49] = 16'h0304; mem.ram[50] = 16'h0506;
      run(CODE_OVERLAP_SAFE_BYTE_MOVE);
      chk("move w0", mem.ram[48], 16'h0101);
      chk("move w1", mem.ram[49], 16'h0203);
      chk("move w2", mem.ram[50], 16'h0406);
      rd(OFF_ACC, 16'h0032, "move src");
      rd(OFF_EXT, 16'h0000, "move slen");
      rd(OFF_INDEX, 16'h0032, "move dst");
      rd(OFF_BASE, 16'h8004, "move dlen");
      rd(OFF_STATUS, 16'h0002, "move status");
      mem.ram[64] = 16'hABCD; mem.ram[80] = 16'h0000;
      setr(16'h0040, 16'h4002, 16'h4003, 16'h0050);
      run(CODE_FORWARD_BYTE_MOVE);
      chk("fwd word", mem.ram[80], 16'hABCD);
      rd(OFF_ACC, 16'h0041, "fwd src");
      rd(OFF_EXT, 16'h4000, "fwd slen");
      rd(OFF_INDEX, 16'h0051, "fwd dst");
      rd(OFF_BASE, 16'h4001, "fwd dlen");
      rd(OFF_STATUS, 16'h0002, "fwd status");
      apb(1'b0, 8'h1C, 16'h0000);
      chk("unmapped", {15'h0000, e}, 16'h0001);
      apb(1'b1, OFF_CMD, 16'h1234);
      rd(OFF_STATUS, 16'h0010, "bad code");
      $display("string test done");
      conclude();
   end
endmodule : test_byte_string_instruction_unit
